// File: src/uhp_pkg.sv
// package: port codes, register indices, memory sizes and carrier structs for the host bus port
package uhp_pkg;

    // port select codes {ctrl_select_addr, cmd_data_select_addr}
    localparam logic [1:0] PORT_HOST_DATA = 2'h0;
    localparam logic [1:0] PORT_HOST_CMD  = 2'h1;
    localparam logic [1:0] PORT_DEV_DATA  = 2'h2;
    localparam logic [1:0] PORT_DEV_CMD   = 2'h3;

    // command byte layout
    localparam int CMD_WRITE_BIT = 7;
    localparam int CMD_IDX_MSB   = 6;

    // host controller register indices
    localparam logic [6:0] HIDX_XFER_CNT   = 7'h22;
    localparam logic [6:0] HIDX_DIR_LEN    = 7'h32;
    localparam logic [6:0] HIDX_DIR_DATA   = 7'h45;
    localparam logic [6:0] HIDX_ISO_A_PORT = 7'h40;
    localparam logic [6:0] HIDX_ISO_B_PORT = 7'h42;
    localparam logic [6:0] HIDX_INTR_PORT  = 7'h43;
    localparam logic [6:0] HIDX_ASYNC_PORT = 7'h41;
    localparam logic [6:0] HIDX_AREA_SIZE  = 7'h30;

    // device controller register indices
    localparam logic [6:0] DIDX_EP_CFG_BASE = 7'h20;
    localparam logic [6:0] DIDX_EP_SELECT   = 7'h02;
    localparam logic [6:0] DIDX_EP_WRITE    = 7'h01;
    localparam logic [6:0] DIDX_EP_READ     = 7'h10;
    localparam logic [6:0] DIDX_ALLOC_STAT  = 7'h0F;

    // memory sizes
    localparam int HOST_MEM_BYTES = 4096;
    localparam int HOST_MEM_WORDS = 2048;
    localparam int DEV_MEM_BYTES  = 2462;
    localparam int DEV_MEM_WORDS  = 1231;
    localparam int NUM_EP         = 16;
    localparam int NUM_AREAS      = 4;

    // direct address/length field layout
    localparam int          DIR_ADDR_BITS   = 15;
    localparam int          DIR_LEN_LSB     = 16;
    localparam logic [14:0] DIR_ADDR_MASK   = 15'h7FFF;

    // endpoint config entry layout and register reset values
    localparam int          EPC_SIZE_MSB  = 9;
    localparam int          EPC_DOUBLE    = 10;
    localparam logic [9:0]  EP_MIN_SIZE   = 10'h010;
    localparam logic [9:0]  EP_MAX_SIZE   = 10'h3FF;
    localparam logic [15:0] EPC_RESET     = 16'h0000;
    localparam logic [15:0] XFER_CNT_RST  = 16'h0000;
    localparam logic [31:0] DIR_LEN_RST   = 32'h00000000;
    localparam logic [15:0] AREA_SIZE_RST = 16'h0400;

    // fifo depth for the streaming path
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 16;

    // pins sampled from the processor side
    typedef struct packed {
        logic        cs_n;
        logic        rd_n;
        logic        wr_n;
        logic        ctrl_select_addr;
        logic        cmd_data_select_addr;
        logic        host_dma_ack_n;
        logic        dev_dma_ack_n;
    } uhp_pins_t;

    // a word travelling to a buffer
    typedef struct packed {
        logic        dev;
        logic [10:0] addr;
        logic [15:0] data;
    } uhp_wr_t;

endpackage

// File: src/uhp_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module uhp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];   // storage
    logic [AW-1:0]    wp_reg;            // write index
    logic [AW-1:0]    rp_reg;            // read index
    logic [AW:0]      cnt_reg;           // occupancy

    wire push = in_valid_i && in_ready_o;
    wire pop  = out_valid_o && out_ready_i;

    // full only at DEPTH entries; a cast to AW bits would wrap DEPTH to zero
    assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem_reg[rp_reg];

    // pointers and count
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            if (pop)
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage has no reset, data only
    always_ff @(posedge clk_sys_i)
    begin
        if (push)
            mem_reg[wp_reg] <= in_data_i;
    end
endmodule

// File: src/uhp_port.sv
// processor bus port: command/data ports, buffer access, two slave dma channels
`timescale 1ns/10ps
module uhp_port (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // processor bus pins
    input  wire logic        cs_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        ctrl_select_addr_i,
    input  wire logic        cmd_data_select_addr_i,
    input  wire logic [15:0] data_i,
    output logic      [15:0] data_o,
    output logic             data_oe_o,
    // dma handshake
    output logic             host_dma_request_o,
    input  wire logic        host_dma_ack_n_i,
    output logic             dev_dma_request_o,
    input  wire logic        dev_dma_ack_n_i,
    // engine-side enables
    input  wire logic        host_dma_enable_i,
    input  wire logic        dev_dma_enable_i,
    input  wire logic        dma_dir_write_i,
    output logic             transfer_end_flag_o
);
    // two-stage pin synchronisers
    uhp_pkg::uhp_pins_t pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic [15:0]        dat_s1_reg, dat_s2_reg;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
            pin_s3_reg <= '1;
            dat_s1_reg <= 16'h0000;
            dat_s2_reg <= 16'h0000;
        end
        else
        begin
            pin_s1_reg <= {cs_n_i, rd_n_i, wr_n_i, ctrl_select_addr_i,
                           cmd_data_select_addr_i, host_dma_ack_n_i, dev_dma_ack_n_i};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            dat_s1_reg <= data_i;
            dat_s2_reg <= dat_s1_reg;
        end
    end

    // strobe edges (falling) on the synchronised copies
    wire        sel      = !pin_s2_reg.cs_n;
    wire        rd_fall  = !pin_s2_reg.rd_n && pin_s3_reg.rd_n;
    wire        wr_fall  = !pin_s2_reg.wr_n && pin_s3_reg.wr_n;
    wire  [1:0] port     = {pin_s2_reg.ctrl_select_addr, pin_s2_reg.cmd_data_select_addr};
    wire        is_dev   = port[1];
    wire        is_cmd   = port[0];
    // cs low: address path wins, acks ignored
    wire        pio_rd   = sel && rd_fall && !is_cmd;
    wire        pio_wr   = sel && wr_fall;
    wire        hack     = !sel && !pin_s2_reg.host_dma_ack_n;
    wire        dack     = !sel && !pin_s2_reg.dev_dma_ack_n;
    // all four dma lines active shuts the port off
    wire        dma_clash = host_dma_request_o && dev_dma_request_o && hack && dack;
    // ack without request is ignored
    wire        h_dma_go = hack && host_dma_request_o && !dma_clash && (rd_fall || wr_fall);
    wire        d_dma_go = dack && dev_dma_request_o && !dma_clash && (rd_fall || wr_fall);

    // command state per controller
    logic [7:0]  hcmd_reg, dcmd_reg;     // last index per controller
    logic        hhalf_reg;              // second data phase pending
    logic [15:0] hlow_reg;               // low half of a 32-bit write
    // host registers
    logic [31:0] direct_addr_len_reg;    // address low, count high
    logic [15:0] byte_transfer_counter_reg;
    logic [15:0] area_size_reg;          // bytes per indirect area
    logic [11:0] hptr_reg;               // host byte pointer
    logic [15:0] hremain_reg;            // bytes left in transfer
    logic [1:0]  harea_reg;              // active indirect area
    // device endpoint state
    logic [15:0] endpoint_cfg_entry_reg [uhp_pkg::NUM_EP];
    logic [15:0] ep_cfg_seen_reg;        // which entries were written
    logic [3:0]  ep_sel_reg;             // selected endpoint
    logic [11:0] dptr_reg;               // device byte pointer in endpoint
    logic [15:0] rdata_reg;              // read data to pins
    logic        oe_reg;
    logic        eot_reg;
    // buffer memories as word arrays
    logic [15:0] hmem_reg [uhp_pkg::HOST_MEM_WORDS];
    logic [15:0] dmem_reg [uhp_pkg::DEV_MEM_WORDS];

    // endpoint area start: sum of earlier sizes, doubled when double buffered
    function automatic logic [11:0] ep_base(input logic [3:0] ep);
        logic [11:0] acc;
        acc = 12'h000;
        for (int i = 0; i < uhp_pkg::NUM_EP; i++)
            if (4'(i) < ep)
                acc = acc + ({2'b00, endpoint_cfg_entry_reg[i][uhp_pkg::EPC_SIZE_MSB:0]}
                      << endpoint_cfg_entry_reg[i][uhp_pkg::EPC_DOUBLE]);
        return acc;
    endfunction

    // clamp endpoint size into its legal range
    function automatic logic [9:0] ep_clamp(input logic [9:0] sz);
        return (sz < uhp_pkg::EP_MIN_SIZE) ? uhp_pkg::EP_MIN_SIZE : sz;
    endfunction

    // the four indirect area ports sit on neighbouring indices
    function automatic logic is_area(input logic [6:0] x);
        return x[6:2] == uhp_pkg::HIDX_ISO_A_PORT[6:2];
    endfunction

    // decode of the live commands
    wire  [6:0]  hidx     = hcmd_reg[uhp_pkg::CMD_IDX_MSB:0];
    wire  [6:0]  didx     = dcmd_reg[uhp_pkg::CMD_IDX_MSB:0];
    wire         hdirect  = (hidx == uhp_pkg::HIDX_DIR_DATA);
    wire         hareap   = is_area(hidx);
    wire  [1:0]  hareasel = hidx[1:0];
    wire         hbuf     = hdirect || hareap;
    wire         depbuf   = (didx == uhp_pkg::DIDX_EP_WRITE) || (didx == uhp_pkg::DIDX_EP_READ);
    wire         alloc_ok = &ep_cfg_seen_reg;
    wire  [11:0] hword    = hptr_reg >> 1;
    wire  [11:0] dbyte    = ep_base(ep_sel_reg) + dptr_reg;
    wire  [10:0] dword    = dbyte[11:1];
    wire         h_more   = (hremain_reg != 16'h0000);

    // words moving into buffers pass the fifo; a full fifo drops the word and the pointer stays
    uhp_pkg::uhp_wr_t wr_in, wr_out;
    logic             f_in_ready, f_out_valid;
    wire  [27:0]      wr_in_bits;
    wire              h_wr_word = (pio_wr && !is_cmd && !is_dev && hbuf && h_more)
                               || (h_dma_go && dma_dir_write_i && h_more);
    wire              d_wr_word = (pio_wr && !is_cmd && is_dev && didx == uhp_pkg::DIDX_EP_WRITE
                                   && alloc_ok) || (d_dma_go && dma_dir_write_i && alloc_ok);
    assign wr_in = '{dev: d_wr_word, addr: d_wr_word ? dword : hword[10:0], data: dat_s2_reg};
    assign wr_in_bits = wr_in;

    uhp_fifo #(.WIDTH(28), .DEPTH(uhp_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  ((h_wr_word || d_wr_word) && f_in_ready),
        .in_ready_o  (f_in_ready),
        .in_data_i   (wr_in_bits),
        .out_valid_o (f_out_valid),
        .out_ready_i (1'b1),
        .out_data_o  (wr_out)
    );

    // drain fifo into memories
    always_ff @(posedge clk_sys_i)
    begin
        if (f_out_valid && wr_out.dev)
            dmem_reg[wr_out.addr] <= wr_out.data;
        else if (f_out_valid)
            hmem_reg[wr_out.addr] <= wr_out.data;
    end

    // command capture and register writes
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hcmd_reg                  <= 8'h00;
            dcmd_reg                  <= 8'h00;
            hhalf_reg                 <= 1'b0;
            hlow_reg                  <= 16'h0000;
            direct_addr_len_reg       <= uhp_pkg::DIR_LEN_RST;
            byte_transfer_counter_reg <= uhp_pkg::XFER_CNT_RST;
            area_size_reg             <= uhp_pkg::AREA_SIZE_RST;
            hptr_reg                  <= 12'h000;
            hremain_reg               <= 16'h0000;
            harea_reg                 <= 2'h0;
            ep_cfg_seen_reg           <= 16'h0000;
            ep_sel_reg                <= 4'h0;
            dptr_reg                  <= 12'h000;
            for (int i = 0; i < uhp_pkg::NUM_EP; i++)
                endpoint_cfg_entry_reg[i] <= uhp_pkg::EPC_RESET;
        end
        else if (pio_wr && is_cmd)
        begin
            // command phase: only the low byte counts
            if (is_dev)
            begin
                dcmd_reg  <= dat_s2_reg[7:0];
                dptr_reg  <= 12'h000;
            end
            else
            begin
                hcmd_reg  <= dat_s2_reg[7:0];
                hhalf_reg <= 1'b0;
                // indirect area port restarts at location 0
                // only area commands reload; other indices keep the direct window
                if (is_area(dat_s2_reg[6:0]))
                begin
                    harea_reg   <= dat_s2_reg[1:0];
                    hptr_reg    <= 12'(dat_s2_reg[1:0] * area_size_reg);
                    hremain_reg <= byte_transfer_counter_reg;
                end
            end
        end
        else if (pio_wr && !is_dev && hcmd_reg[uhp_pkg::CMD_WRITE_BIT] && !hbuf)
        begin
            // register data phase, low half first
            hhalf_reg <= !hhalf_reg;
            if (!hhalf_reg)
                hlow_reg <= dat_s2_reg;
            if (hidx == uhp_pkg::HIDX_XFER_CNT)
                byte_transfer_counter_reg <= dat_s2_reg;
            if (hidx == uhp_pkg::HIDX_AREA_SIZE)
                area_size_reg <= dat_s2_reg;
            if (hidx == uhp_pkg::HIDX_DIR_LEN && hhalf_reg)
            begin
                direct_addr_len_reg <= {dat_s2_reg, 1'b0, hlow_reg[14:0]};
                hptr_reg            <= hlow_reg[11:0];
                hremain_reg         <= dat_s2_reg;
            end
        end
        else if (pio_wr && is_dev && dcmd_reg[uhp_pkg::CMD_WRITE_BIT] && !depbuf)
        begin
            // device side: endpoint configuration and selection
            if (didx[6:4] == uhp_pkg::DIDX_EP_CFG_BASE[6:4])
            begin
                endpoint_cfg_entry_reg[didx[3:0]] <=
                    {dat_s2_reg[15:11], dat_s2_reg[uhp_pkg::EPC_DOUBLE],
                     ep_clamp(dat_s2_reg[uhp_pkg::EPC_SIZE_MSB:0])};
                ep_cfg_seen_reg[didx[3:0]] <= 1'b1;
            end
            if (didx == uhp_pkg::DIDX_EP_SELECT)
            begin
                ep_sel_reg <= dat_s2_reg[3:0];
                dptr_reg   <= 12'h000;
            end
        end
        else
        begin
            // register reads step through the halves of a 32-bit value
            if (pio_rd && !is_dev && !hbuf)
                hhalf_reg <= !hhalf_reg;
            // buffer words: pointer up two, host count down two
            if ((pio_rd && !is_dev && hbuf && h_more) || h_wr_word && f_in_ready
                || (h_dma_go && !dma_dir_write_i && h_more))
            begin
                hptr_reg    <= hptr_reg + 12'h002;
                hremain_reg <= (hremain_reg < 16'h0002) ? 16'h0000
                             : hremain_reg - 16'h0002;
            end
            if ((pio_rd && is_dev && depbuf) || (d_wr_word && f_in_ready)
                || (d_dma_go && !dma_dir_write_i))
                dptr_reg <= dptr_reg + 12'h002;
        end
    end

    // read data: register reads and buffer reads; command ports are write only
    wire [15:0] hreg_val =
        (hidx == uhp_pkg::HIDX_XFER_CNT)  ? byte_transfer_counter_reg :
        (hidx == uhp_pkg::HIDX_AREA_SIZE) ? area_size_reg :
        (hidx == uhp_pkg::HIDX_DIR_LEN)   ? (hhalf_reg ? direct_addr_len_reg[31:16]
                                                       : direct_addr_len_reg[15:0]) :
        hbuf ? hmem_reg[hword[10:0]] : 16'h0000;
    wire [15:0] dreg_val =
        (didx == uhp_pkg::DIDX_EP_READ)    ? dmem_reg[dword] :
        (didx == uhp_pkg::DIDX_ALLOC_STAT) ? ep_cfg_seen_reg :
        (didx[6:4] == uhp_pkg::DIDX_EP_CFG_BASE[6:4]) ? endpoint_cfg_entry_reg[didx[3:0]] :
        16'h0000;

    // pin data, drive enable and dma requests
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_reg          <= 16'h0000;
            oe_reg             <= 1'b0;
            eot_reg            <= 1'b0;
            host_dma_request_o <= 1'b0;
            dev_dma_request_o  <= 1'b0;
        end
        else
        begin
            // dma writes leave the read word alone
            if (pio_rd || ((h_dma_go || d_dma_go) && !dma_dir_write_i))
                rdata_reg <= (pio_rd ? is_dev : d_dma_go) ? dreg_val : hreg_val;
            // drive while a read strobe is low on a data port or acked channel
            oe_reg <= !pin_s2_reg.rd_n && ((sel && !is_cmd) || (!sel && !dma_clash
                      && ((hack && host_dma_request_o) || (dack && dev_dma_request_o))));
            // host channel stops on the internal end of transfer
            host_dma_request_o <= host_dma_enable_i && h_more && !eot_reg;
            dev_dma_request_o  <= dev_dma_enable_i && alloc_ok;
            eot_reg <= h_dma_go && (hremain_reg <= 16'h0002);
        end
    end

    assign data_o              = rdata_reg;
    assign data_oe_o           = oe_reg;
    assign transfer_end_flag_o = eot_reg;
endmodule

// File: tb/uhp_port_props.sv
// checker: timing relations seen at the bus port pins
`timescale 1ns/10ps
module uhp_port_props (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    // processor bus
    input wire logic        cs_n_i,
    input wire logic        rd_n_i,
    input wire logic        cmd_data_select_addr_i,
    input wire logic [15:0] data_o,
    input wire logic        data_oe_o,
    // dma side
    input wire logic        host_dma_enable_i,
    input wire logic        dev_dma_enable_i,
    input wire logic        host_dma_request_o,
    input wire logic        dev_dma_request_o,
    input wire logic        transfer_end_flag_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // outputs quiet while reset holds
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |-> !data_oe_o
        && !host_dma_request_o && !dev_dma_request_o && !transfer_end_flag_o)
        else $error("output active in reset");
    // a held data read must drive the bus
    a_read_drives: assert property ((!cs_n_i && !rd_n_i && !cmd_data_select_addr_i)[*6]
        |-> data_oe_o) else $error("data read not driven");
    // command ports are write only
    a_cmd_quiet: assert property ((!cs_n_i && !rd_n_i && cmd_data_select_addr_i)[*5]
        |-> !data_oe_o) else $error("command port read driven");
    // no drive and no data change without a read
    a_idle_bus: assert property (rd_n_i[*6] |-> !data_oe_o && $stable(data_o))
        else $error("bus driven or changed without read");
    // end of transfer is a single pulse and ends the request
    a_eot_pulse: assert property (transfer_end_flag_o |=> !transfer_end_flag_o)
        else $error("end flag longer than one cycle");
    a_eot_stops: assert property (transfer_end_flag_o |-> ##[1:4] !host_dma_request_o)
        else $error("request kept after end");
    // requests need their channel enabled
    a_host_idle: assert property (!host_dma_enable_i[*2] |-> !host_dma_request_o)
        else $error("host request while disabled");
    a_dev_idle: assert property (!dev_dma_enable_i[*2] |-> !dev_dma_request_o)
        else $error("device request while disabled");
    // selected chip blocks dma completion
    a_cs_first: assert property (!cs_n_i[*6] |-> !transfer_end_flag_o)
        else $error("dma ended while chip selected");
endmodule

// File: tb/uhp_dma_model.sv
// dma master stand-in: paces acknowledges while the port requests
`timescale 1ns/10ps
module uhp_dma_model #(
    parameter int GAP = 1 // idle clocks between acks less one; large means slow master
) (
    // clock
    input  wire logic clk_sys_i,
    // handshake
    input  wire logic req_i,
    input  wire logic bus_free_i,
    output logic      ack_n_o,
    output logic      str_n_o
);
    int cnt = 0; // place within one ack cycle
    initial ack_n_o = 1'b1;
    initial str_n_o = 1'b1;
    // ack low four clocks, write strobe low for three inside it; never while selected
    always @(negedge clk_sys_i)
    begin
        cnt     <= (!req_i || cnt >= 4 + GAP) ? 0 : cnt + 1;
        ack_n_o <= !(req_i && bus_free_i && cnt < 4);
        str_n_o <= !(req_i && bus_free_i && cnt > 0 && cnt < 4);
    end
endmodule

// File: tb/tb_top.sv
// testbench: processor cycles and two dma masters around the bus port
`timescale 1ns/10ps
module tb_top;
    logic        clk_sys_i, rst_i, cs_n_i, rd_n_i, wr_n_i, oe; // clock, reset, strobes
    logic        ctrl_select_addr_i, cmd_data_select_addr_i;  // port select
    logic [15:0] data_i, data_o, q;                            // bus words
    logic        data_oe_o, host_dma_request_o, dev_dma_request_o, transfer_end_flag_o;
    logic        host_dma_ack_n_i, dev_dma_ack_n_i, dma_dir_write_i;
    logic        host_dma_enable_i, dev_dma_enable_i;
    logic        host_str_n, dev_str_n;                        // dma master strobes
    wire         wr_n_pin = wr_n_i && host_str_n && dev_str_n; // shared write strobe
    int          n_errors = 0, num_checks = 0, i;
    uhp_port i_uhp_port (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
        .rd_n_i(rd_n_i), .wr_n_i(wr_n_pin), .ctrl_select_addr_i(ctrl_select_addr_i),
        .cmd_data_select_addr_i(cmd_data_select_addr_i), .data_i(data_i), .data_o(data_o),
        .data_oe_o(data_oe_o), .host_dma_request_o(host_dma_request_o),
        .host_dma_ack_n_i(host_dma_ack_n_i), .dev_dma_request_o(dev_dma_request_o),
        .dev_dma_ack_n_i(dev_dma_ack_n_i), .host_dma_enable_i(host_dma_enable_i),
        .dev_dma_enable_i(dev_dma_enable_i), .dma_dir_write_i(dma_dir_write_i),
        .transfer_end_flag_o(transfer_end_flag_o));
    // fast master on the host channel, slow one on the device channel
    uhp_dma_model #(.GAP(1)) i_host_dma (.clk_sys_i(clk_sys_i), .req_i(host_dma_request_o),
        .bus_free_i(cs_n_i), .ack_n_o(host_dma_ack_n_i), .str_n_o(host_str_n));
    uhp_dma_model #(.GAP(5)) i_dev_dma (.clk_sys_i(clk_sys_i), .req_i(dev_dma_request_o),
        .bus_free_i(cs_n_i), .ack_n_o(dev_dma_ack_n_i), .str_n_o(dev_str_n));
    // free running system clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // one bus cycle; strobe held six clocks so the synchronisers see it
    task automatic acc(input logic [1:0] p, input logic w, input logic [15:0] d);
        @(negedge clk_sys_i);
        {ctrl_select_addr_i, cmd_data_select_addr_i} = p;
        data_i = d;
        {cs_n_i, rd_n_i, wr_n_i} = {1'b0, w, !w};
        repeat (6) @(negedge clk_sys_i);
        q = data_o;
        oe = data_oe_o;
        {cs_n_i, rd_n_i, wr_n_i} = 3'h7;
        data_i = ~d; // a released bus must not keep the old word
        repeat (4) @(negedge clk_sys_i);
    endtask
    // command phase: index in low byte, top bit says write
    task automatic cmd(input logic c, input logic w, input logic [6:0] x);
        acc({c, 1'b1}, 1'b1, {8'h00, w, x});
    endtask
    task automatic wreg(input logic c, input logic [6:0] x, input logic [15:0] d);
        cmd(c, 1'b1, x);
        acc({c, 1'b0}, 1'b1, d);
    endtask
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // data phase read and compare
    task automatic rchk(input logic c, input string s, input logic [15:0] e);
        acc({c, 1'b0}, 1'b0, 16'h0000);
        chk(s, e, q);
    endtask
    // direct window: start low, byte count high
    task automatic setdir(input logic [14:0] a, input logic [15:0] n);
        wreg(1'b0, uhp_pkg::HIDX_DIR_LEN, {1'b0, a});
        acc(2'h0, 1'b1, n);
    endtask
    task automatic test_done;
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {rst_i, cs_n_i, rd_n_i, wr_n_i, dev_dma_enable_i, dma_dir_write_i} = 6'h3F;
        {ctrl_select_addr_i, cmd_data_select_addr_i, host_dma_enable_i} = 3'h0;
        data_i = 16'h0000;
        repeat (12) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk("dev_req_unconfigured", 16'h0, {15'h0, dev_dma_request_o});
        dev_dma_enable_i = 1'b0;
        acc(uhp_pkg::PORT_HOST_CMD, 1'b0, 16'h0000);
        chk("cmd_read_oe", 16'h0, {15'h0, oe});
        setdir(15'd20, 16'd2);
        cmd(1'b0, 1'b1, uhp_pkg::HIDX_DIR_DATA);
        acc(2'h0, 1'b1, 16'h1111);
        setdir(15'd16, 16'd4);
        cmd(1'b0, 1'b0, uhp_pkg::HIDX_DIR_LEN);
        rchk(1'b0, "dir_len_low", 16'h0010);
        rchk(1'b0, "dir_len_high", 16'h0004);
        cmd(1'b0, 1'b1, uhp_pkg::HIDX_DIR_DATA);
        acc(2'h0, 1'b1, 16'hA5A5);
        acc(2'h0, 1'b1, 16'h5A5A);
        acc(2'h0, 1'b1, 16'hFFFF);
        setdir(15'd16, 16'd6);
        cmd(1'b0, 1'b0, uhp_pkg::HIDX_DIR_DATA);
        rchk(1'b0, "dir_word0", 16'hA5A5);
        rchk(1'b0, "dir_word1", 16'h5A5A);
        rchk(1'b0, "dir_word2", 16'h1111);
        wreg(1'b0, uhp_pkg::HIDX_XFER_CNT, 16'h0004);
        cmd(1'b0, 1'b1, uhp_pkg::HIDX_ASYNC_PORT);
        acc(2'h0, 1'b1, 16'hC0DE);
        acc(2'h0, 1'b1, 16'hBEEF);
        setdir(15'h0400, 16'd4);
        cmd(1'b0, 1'b0, uhp_pkg::HIDX_DIR_DATA);
        rchk(1'b0, "area_word0", 16'hC0DE);
        rchk(1'b0, "area_word1", 16'hBEEF);
        cmd(1'b0, 1'b0, uhp_pkg::HIDX_ASYNC_PORT);
        rchk(1'b0, "area_read0", 16'hC0DE);
        for (i = 0; i < uhp_pkg::NUM_EP; i++)
            wreg(1'b1, uhp_pkg::DIDX_EP_CFG_BASE + 7'(i),
                (i == 14) ? 16'h03FF : (i == 15) ? 16'h0410 : 16'h0040);
        cmd(1'b1, 1'b0, uhp_pkg::DIDX_ALLOC_STAT);
        rchk(1'b1, "ep_cfg_bitmap", 16'hFFFF);
        wreg(1'b1, uhp_pkg::DIDX_EP_SELECT, 16'h0002);
        wreg(1'b1, uhp_pkg::DIDX_EP_WRITE, 16'h1234);
        wreg(1'b1, uhp_pkg::DIDX_EP_SELECT, 16'h0002);
        cmd(1'b1, 1'b0, uhp_pkg::DIDX_EP_READ);
        rchk(1'b1, "ep_word", 16'h1234);
        dev_dma_enable_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk("dev_req_configured", 16'h1, {15'h0, dev_dma_request_o});
        dev_dma_enable_i = 1'b0;
        wreg(1'b0, uhp_pkg::HIDX_XFER_CNT, 16'h0004);
        cmd(1'b0, 1'b1, uhp_pkg::HIDX_INTR_PORT);
        host_dma_enable_i = 1'b1;
        for (i = 0; i < 300 && transfer_end_flag_o !== 1'b1; i++)
            @(negedge clk_sys_i);
        chk("end_flag_seen", 16'h1, {15'h0, transfer_end_flag_o});
        host_dma_enable_i = 1'b0;
        test_done();
    end
    // hang guard well past the expected run length
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        test_done();
    end
endmodule
bind uhp_port uhp_port_props i_uhp_port_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .cmd_data_select_addr_i(cmd_data_select_addr_i),
    .data_o(data_o), .data_oe_o(data_oe_o), .host_dma_enable_i(host_dma_enable_i),
    .dev_dma_enable_i(dev_dma_enable_i), .host_dma_request_o(host_dma_request_o),
    .dev_dma_request_o(dev_dma_request_o), .transfer_end_flag_o(transfer_end_flag_o));
